// ==== rtl/stack_recognizer_map.svh ====
// Port addresses, control codes and layout constants for the stack word recognizer
`ifndef STACK_RECOGNIZER_MAP_SVH
`define STACK_RECOGNIZER_MAP_SVH
`define PORT_RAM_A_WRITE 8'h04
`define PORT_RAM_B_WRITE 8'h05
`define PORT_RAM_C_WRITE 8'h06
`define PORT_READBACK 8'h0E
`define PORT_POINTER_CTRL 8'h10
`define PORT_CLOCK_ENABLE_CTRL 8'h11
`define PORT_CLOCK_SOURCE_CTRL 8'h12
`define PORT_POINTER_VALUE 8'h13
`define CODE_POINTER_LOAD 8'h80
`define CODE_CLOCK_ENABLE_ALL 8'h00
`define CODE_SINGLE_STEP 8'h80
`define RAM_DEPTH 4096
`define POINTER_BITS 4
`define DATA_ADDR_BITS 8
`define READBACK_LSB 5
`endif

// ==== rtl/stack_recognizer_pkg.sv ====
// Types shared by the stack word recognizer
package stack_recognizer_pkg;
  typedef logic [2:0] recognizer_word_t;
  typedef logic [11:0] recognizer_addr_t;
endpackage

// ==== rtl/stack_word_recognizer.sv ====
// Stack word recognizer memory with diagnostic load and readback ports
// Notes on behaviour
// - Three 1-bit RAMs form one 4096x3 memory
// - Loaded bits go A low, B middle, C high
// - Address: pointer low four, logged data high eight
// - Writing 80 to pointer control drives load low
// - Writing 00 to enable port lowers enables
// - Writing 80 to clock source enables single step
// - Ports 04/05/06 write RAM A/B/C
// - RAM outputs on top three readback bits
// - Readback reverses order: A top, C lowest
// - Word recognized when all three outputs high
// - Pointer increments to watch next sequence word
`timescale 1ns/1ps
`include "stack_recognizer_map.svh"
module stack_word_recognizer #(
  parameter int DEPTH = `RAM_DEPTH
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Controller port bus
  input wire logic [7:0] i_port_addr,
  input wire logic i_port_write,
  input wire logic [7:0] i_local_write_bus,
  input wire logic i_recognizer_read_strobe,
  output logic [7:0] o_port_rdata,
  // Acquisition side
  input wire logic [7:0] i_logged_data_bus,
  input wire logic i_sequence_advance,
  // Control levels
  output logic o_pointer_load_n,
  output logic o_stack_clock_enable_n,
  output logic [2:0] o_ram_diag_enable_n,
  output logic o_single_step_enable,
  // Recognizer status
  output logic [2:0] o_recognizer_out_bus,
  output logic o_word_recognized,
  output logic [3:0] o_sequence_pointer_bus
);

  // Design intent for the next engineer:
  // All three RAMs share one address, so a fault on one address line
  // shows on all three RAM bits of the readback word, not on one RAM alone.
  // RAM contents have no reset; the recognizer output is unknown
  // until the host has loaded the location it is looking at.
  // Writes land one clock after the port write, because the strobe
  // and its data bits are registered first. That costs a cycle but
  // keeps the RAM enables glitch-free and one clock wide.
  // The readback word is also registered, so a read taken on one
  // edge shows the word that stood at that edge one clock later.
  // After a change of pointer or logged data, allow three clocks for
  // the synchroniser and the registered RAM word to settle.
  // Limitation: the pointer value port is ignored unless load mode
  // has first been selected on the pointer control port.

  // Recognizer storage, one array per RAM
  logic ram_a [DEPTH];
  logic ram_b [DEPTH];
  logic ram_c [DEPTH];

  // Logged data from the acquisition domain, two-flop synchronised
  logic [7:0] data_meta_q;
  logic [7:0] data_sync_q;
  logic advance_meta_q;
  logic advance_sync_q;

  // Control state
  logic pointer_load_n_q, pointer_load_n_d;
  logic clock_enable_n_q, clock_enable_n_d;
  logic [2:0] diag_enable_n_q, diag_enable_n_d;
  logic single_step_q, single_step_d;
  logic [3:0] pointer_q, pointer_d;
  logic [2:0] we_q, we_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] word_q;

  // Combined address and write decode
  // Address is twelve bits: data high, pointer low
  stack_recognizer_pkg::recognizer_addr_t addr;
  // One decode per control port, all qualified by the write strobe
  logic hit_ptr, hit_en, hit_src, hit_val;

  // Synchronisers: first stage read only by second
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      data_meta_q <= 8'h00;
      data_sync_q <= 8'h00;
      advance_meta_q <= 1'b0;
      advance_sync_q <= 1'b0;
    end else begin
      data_meta_q <= i_logged_data_bus;
      data_sync_q <= data_meta_q;
      advance_meta_q <= i_sequence_advance;
      advance_sync_q <= advance_meta_q;
    end
  end

  assign addr = {data_sync_q, pointer_q};

  // Port decodes; other addresses are simply ignored
  assign hit_ptr = i_port_write && (i_port_addr == `PORT_POINTER_CTRL);
  assign hit_en = i_port_write && (i_port_addr == `PORT_CLOCK_ENABLE_CTRL);
  assign hit_src = i_port_write && (i_port_addr == `PORT_CLOCK_SOURCE_CTRL);
  assign hit_val = i_port_write && (i_port_addr == `PORT_POINTER_VALUE);

  // Next-state for control ports, pointer and write strobes
  always_comb begin
    pointer_load_n_d = pointer_load_n_q;
    clock_enable_n_d = clock_enable_n_q;
    diag_enable_n_d = diag_enable_n_q;
    single_step_d = single_step_q;
    pointer_d = pointer_q;
    we_d = 3'b000;
    // Load control follows pointer port code
    // Any other code releases load mode and allows counting
    if (hit_ptr) begin
      pointer_load_n_d = (i_local_write_bus != `CODE_POINTER_LOAD);
    end
    if (hit_en) begin
      clock_enable_n_d = (i_local_write_bus != `CODE_CLOCK_ENABLE_ALL);
      diag_enable_n_d = {3{i_local_write_bus != `CODE_CLOCK_ENABLE_ALL}};
    end
    // Single-step clock source select
    // Any code but the single-step one returns to the normal clock
    if (hit_src) begin
      single_step_d = (i_local_write_bus == `CODE_SINGLE_STEP);
    end
    // Pointer loads only while load control is low
    // A load wins over a count that falls in the same clock
    if (hit_val && !pointer_load_n_q) begin
      pointer_d = i_local_write_bus[3:0];
    end else if (advance_sync_q && !clock_enable_n_q && pointer_load_n_q) begin
      pointer_d = pointer_q + 4'h1;
    end
    // One enable per write port
    // Strobes default low above, so each lasts one clock only
    if (i_port_write) begin
      we_d[0] = (i_port_addr == `PORT_RAM_A_WRITE);
      we_d[1] = (i_port_addr == `PORT_RAM_B_WRITE);
      we_d[2] = (i_port_addr == `PORT_RAM_C_WRITE);
    end
  end

  // Write data held with the strobe
  // Registered together with the strobe so both meet the RAM at once
  logic [2:0] wbits_q;

  // Register control state
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      pointer_load_n_q <= 1'b1;
      clock_enable_n_q <= 1'b1;
      diag_enable_n_q <= 3'b111;
      single_step_q <= 1'b0;
      pointer_q <= 4'h0;
      we_q <= 3'b000;
      wbits_q <= 3'b000;
    end else begin
      pointer_load_n_q <= pointer_load_n_d;
      clock_enable_n_q <= clock_enable_n_d;
      diag_enable_n_q <= diag_enable_n_d;
      single_step_q <= single_step_d;
      pointer_q <= pointer_d;
      we_q <= we_d;
      wbits_q <= i_local_write_bus[2:0];
    end
  end

  // Shared address, A takes bit 0, C bit 2
  // No reset here: the storage models plain RAM without clear
  always_ff @(posedge i_clock) begin
    if (we_q[0]) ram_a[addr] <= wbits_q[0];
    if (we_q[1]) ram_b[addr] <= wbits_q[1];
    if (we_q[2]) ram_c[addr] <= wbits_q[2];
    word_q <= {ram_c[addr], ram_b[addr], ram_a[addr]};
  end

  // Readback reversed in top three bits
  always_comb begin
    rdata_d = 8'h00;
    if (i_recognizer_read_strobe && i_port_addr == `PORT_READBACK) begin
      // Low five bits read as zero
      rdata_d = {word_q[0], word_q[1], word_q[2], 5'h00};
    end
  end

  // Register readback data
  // Held only one clock, then back to zero
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from registers, except the AND below
  assign o_port_rdata = rdata_q;
  assign o_pointer_load_n = pointer_load_n_q;
  assign o_stack_clock_enable_n = clock_enable_n_q;
  assign o_ram_diag_enable_n = diag_enable_n_q;
  assign o_single_step_enable = single_step_q;
  assign o_recognizer_out_bus = word_q;
  assign o_word_recognized = &word_q;
  assign o_sequence_pointer_bus = pointer_q;

  // Checks below watch registered outputs one clock after the cause; one-hot and AND checks use the same clock, stored-bit checks two clocks
  // Enables are one-hot or all low
  write_onehot_a: assert property (@(posedge i_clock) disable iff (i_srst)
    $onehot0(we_q))
    else $error("write enable not one-hot");
  // Each strobe follows one port write
  write_pulse_a: assert property (@(posedge i_clock) disable iff (i_srst)
    we_q != 3'b000 |-> $past(i_port_write))
    else $error("write enable without port write");
  // Port 04 write hits RAM A only
  port_a_we_a: assert property (@(posedge i_clock) disable iff (i_srst)
    i_port_write && i_port_addr == `PORT_RAM_A_WRITE |=> we_q == 3'b001)
    else $error("port 04 did not strobe RAM A");
  // Port 06 write hits RAM C only
  port_c_we_a: assert property (@(posedge i_clock) disable iff (i_srst)
    i_port_write && i_port_addr == `PORT_RAM_C_WRITE |=> we_q == 3'b100)
    else $error("port 06 did not strobe RAM C");
  // Stored bit reappears on its own output
  for (genvar b = 0; b < 3; b++) begin : g_store_chk
    ram_store_a: assert property (@(posedge i_clock) disable iff (i_srst)
      we_q[b] ##1 $stable(addr) |=> o_recognizer_out_bus[b] == $past(wbits_q[b], 2))
      else $error("stored bit not read back");
  end
  // Reset values of control state and readback
  reset_state_a: assert property (@(posedge i_clock)
    i_srst |=> o_pointer_load_n && o_stack_clock_enable_n && o_ram_diag_enable_n == 3'b111
      && !o_single_step_enable && o_sequence_pointer_bus == 4'h0 && o_port_rdata == 8'h00)
    else $error("reset state wrong");
  // Readback is zero unless recognizer_readback was read
  readback_idle_a: assert property (@(posedge i_clock) disable iff (i_srst)
    !(i_recognizer_read_strobe && i_port_addr == `PORT_READBACK) |=> o_port_rdata == 8'h00)
    else $error("readback not idle");
  // Port 05 write hits RAM B only
  port_b_we_a: assert property (@(posedge i_clock) disable iff (i_srst)
    i_port_write && i_port_addr == `PORT_RAM_B_WRITE |=> we_q == 3'b010)
    else $error("port 05 did not strobe RAM B");
  load_ctrl_a: assert property (@(posedge i_clock) disable iff (i_srst)
    hit_ptr && i_local_write_bus == `CODE_POINTER_LOAD |=> !o_pointer_load_n)
    else $error("pointer load not low after 80");
  load_release_a: assert property (@(posedge i_clock) disable iff (i_srst)
    hit_ptr && i_local_write_bus != `CODE_POINTER_LOAD |=> o_pointer_load_n)
    else $error("pointer load not released");
  // Load mode accepts the pointer value
  pointer_load_a: assert property (@(posedge i_clock) disable iff (i_srst)
    hit_val && !pointer_load_n_q |=> o_sequence_pointer_bus == $past(i_local_write_bus[3:0]))
    else $error("pointer value not loaded");
  enable_ctrl_a: assert property (@(posedge i_clock) disable iff (i_srst)
    hit_en && i_local_write_bus == `CODE_CLOCK_ENABLE_ALL
    |=> !o_stack_clock_enable_n && o_ram_diag_enable_n == 3'b000)
    else $error("enables not low after 00");
  enable_release_a: assert property (@(posedge i_clock) disable iff (i_srst)
    hit_en && i_local_write_bus != `CODE_CLOCK_ENABLE_ALL
    |=> o_stack_clock_enable_n && o_ram_diag_enable_n == 3'b111)
    else $error("enables not high after other code");
  single_step_a: assert property (@(posedge i_clock) disable iff (i_srst)
    hit_src && i_local_write_bus == `CODE_SINGLE_STEP |=> o_single_step_enable)
    else $error("single step not enabled");
  // Other codes leave single step off
  single_step_off_a: assert property (@(posedge i_clock) disable iff (i_srst)
    hit_src && i_local_write_bus != `CODE_SINGLE_STEP |=> !o_single_step_enable)
    else $error("single step not disabled");
  readback_order_a: assert property (@(posedge i_clock) disable iff (i_srst)
    i_recognizer_read_strobe && i_port_addr == `PORT_READBACK
    |=> o_port_rdata == {$past(word_q[0]), $past(word_q[1]), $past(word_q[2]), 5'h00})
    else $error("readback order wrong");
  recognize_and_a: assert property (@(posedge i_clock) disable iff (i_srst)
    o_word_recognized == (word_q == 3'b111))
    else $error("recognition not AND of outputs");
  pointer_step_a: assert property (@(posedge i_clock) disable iff (i_srst)
    advance_sync_q && !clock_enable_n_q && pointer_load_n_q && !hit_val
    |=> pointer_q == $past(pointer_q) + 4'h1)
    else $error("pointer did not increment");
  // Pointer holds when neither counting nor loading
  pointer_hold_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (clock_enable_n_q || !advance_sync_q) && !(hit_val && !pointer_load_n_q)
    |=> pointer_q == $past(pointer_q))
    else $error("pointer moved while idle");
endmodule

// ==== sim/host_port_model.sv ====
// Host controller model that drives the diagnostic port bus
`timescale 1ns/1ps
module host_port_model (
  // Clock
  input wire logic i_clock,
  // Port bus towards the recognizer
  output logic [7:0] o_port_addr,
  output logic o_port_write,
  output logic [7:0] o_wdata,
  output logic o_read_strobe,
  input wire logic [7:0] i_rdata
);
  // Idle bus at time zero
  initial begin
    o_port_addr = 8'h00;
    o_port_write = 1'b0;
    o_wdata = 8'h00;
    o_read_strobe = 1'b0;
  end
  // one write strobe per port write
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_clock);
    #10;
    o_port_addr = addr;
    o_wdata = data;
    o_port_write = 1'b1;
    @(posedge i_clock);
    #10;
    o_port_write = 1'b0;
    // Released lines flip so stale values never pass
    o_port_addr = ~addr;
    o_wdata = ~data;
  endtask
  // strobed read of the readback port
  task automatic rd(output logic [7:0] data);
    @(posedge i_clock);
    #10;
    o_port_addr = 8'h0e;
    o_read_strobe = 1'b1;
    @(posedge i_clock);
    #10;
    o_read_strobe = 1'b0;
    o_port_addr = 8'hf1;
    // Registered answer stands just after the taking edge, so it is read 10 ns later
    data = i_rdata;
  endtask
endmodule

// ==== sim/stack_word_recognizer_bench.sv ====
// Self-checking bench for the stack word recognizer
`timescale 1ns/1ps
module stack_word_recognizer_bench;
  logic clock, srst, adv, wr_s, rd_s, load_n, cen_n, step, word;
  logic [7:0] addr, wdata, rdata, logged, got;
  logic [2:0] diag_n, rec;
  logic [3:0] ptr;
  int err_count, n_tests;
  // Locations: boundary pointers and data, then pointer 5 at data 3c; rotating one-hot then all ones
  logic [3:0] ptrs [5] = '{4'h0, 4'hf, 4'h0, 4'hf, 4'h5};
  logic [7:0] dats [5] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h3c};
  logic [2:0] pats [5] = '{3'b010, 3'b001, 3'b100, 3'b010, 3'b111};
  host_port_model h (.i_clock(clock), .o_port_addr(addr), .o_port_write(wr_s),
    .o_wdata(wdata), .o_read_strobe(rd_s), .i_rdata(rdata));
  stack_word_recognizer DUT (.i_clock(clock), .i_srst(srst), .i_port_addr(addr),
    .i_port_write(wr_s), .i_local_write_bus(wdata), .i_recognizer_read_strobe(rd_s),
    .o_port_rdata(rdata), .i_logged_data_bus(logged), .i_sequence_advance(adv),
    .o_pointer_load_n(load_n), .o_stack_clock_enable_n(cen_n),
    .o_ram_diag_enable_n(diag_n), .o_single_step_enable(step),
    .o_recognizer_out_bus(rec), .o_word_recognized(word), .o_sequence_pointer_bus(ptr));
  // Free-running 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Byte compare with report
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Address one location, optionally loading all three RAMs
  task automatic put(input int k, input bit load);
    @(posedge clock);
    #10;
    logged = dats[k];
    h.wr(8'h13, {4'h0, ptrs[k]});
    if (load) begin
      h.wr(8'h04, {5'h00, pats[k]});
      h.wr(8'h05, {5'h00, pats[k]});
      h.wr(8'h06, {5'h00, pats[k]});
    end
    repeat (3) @(posedge clock);
  endtask
  // Verdict and end of run
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    srst = 1'b1;
    adv = 1'b0;
    logged = 8'h00;
    err_count = 0;
    n_tests = 0;
    repeat (6) @(posedge clock);
    #10;
    srst = 1'b0;
    h.wr(8'h10, 8'h80);
    chk({7'h00, load_n}, 8'h00);
    h.wr(8'h11, 8'h00);
    chk({4'h0, cen_n, diag_n}, 8'h00);
    h.wr(8'h12, 8'h80);
    chk({7'h00, step}, 8'h01);
    $display("Test controls done");
    for (int k = 0; k < 5; k++) put(k, 1'b1);
    for (int k = 0; k < 5; k++) begin
      put(k, 1'b0);
      h.rd(got);
      chk(got, {pats[k][0], pats[k][1], pats[k][2], 5'h00});
      chk({4'h0, word, rec}, {4'h0, &pats[k], pats[k]});
    end
    $display("Test memory done");
    h.wr(8'h10, 8'h90);
    @(posedge clock);
    #10;
    adv = 1'b1;
    @(posedge clock);
    #10;
    adv = 1'b0;
    repeat (4) @(posedge clock);
    #10;
    chk({4'h0, ptr}, 8'h06);
    h.wr(8'h11, 8'h01);
    chk({4'h0, cen_n, diag_n}, 8'h0f);
    h.wr(8'h12, 8'h00);
    chk({7'h00, step}, 8'h00);
    $display("Test pointer done");
    end_sim();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #(100 * 3000);
    err_count++;
    end_sim();
  end
endmodule
